// ===== shared/tbs_pkg.sv
// Function
// - walk disable base one gives section fault
// - walk disable base zero gives section fault
// - clear disable bits allow walk, world privilege
// - boundary field encodes 16KB down to 128B
// - boundary zero always selects base zero
// - upper address bits zero select base zero
// - secure write under lock is undefined
// - user mode access is undefined
// - secure and non-secure register copies
// - control register at op1 0 c2 c0 2
// - domain register at op1 0 c3 c0 0
// - sixteen two-bit domain fields
// - domain code 00 gives domain fault
// - domain code 01 checks permissions
// - domain code 10 gives domain fault
// - domain code 11 bypasses permission checks
// - base zero address bits used follow boundary; base one always from bit 14
package tbs_pkg;
  localparam logic [2:0] TBS_OP1_CTRL = 3'h0;
  localparam logic [3:0] TBS_CRN_CTRL = 4'h2;
  localparam logic [3:0] TBS_CRM_CTRL = 4'h0;
  localparam logic [2:0] TBS_OP2_CTRL = 3'h2;
  localparam logic [2:0] TBS_OP1_DOM = 3'h0;
  localparam logic [3:0] TBS_CRN_DOM = 4'h3;
  localparam logic [3:0] TBS_CRM_DOM = 4'h0;
  localparam logic [2:0] TBS_OP2_DOM = 3'h0;
  localparam int TBS_BND_LSB = 0;
  localparam int TBS_BND_W = 3;
  localparam int TBS_WD0_BIT = 4;
  localparam int TBS_WD1_BIT = 5;
  localparam logic [31:0] TBS_CTRL_MASK = 32'h0000_0037;
  localparam logic [31:0] TBS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TBS_DOM_RST = 32'h0000_0000;
  localparam int TBS_NUM_DOM = 16;
  localparam logic [1:0] TBS_DOM_NOACC = 2'h0;
  localparam logic [1:0] TBS_DOM_CLIENT = 2'h1;
  localparam logic [1:0] TBS_DOM_RSVD = 2'h2;
  localparam logic [1:0] TBS_DOM_MANAGER = 2'h3;
  localparam logic [1:0] TBS_BASE_ALIGN_LSB = 2'h0;
  localparam logic [4:0] TBS_BASE_LSB_MAX = 5'h0E;
endpackage : tbs_pkg

// ===== rtl/tbs_base_select.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_base_select
  import tbs_pkg::*;
(
  // control
  input wire logic [2:0] i_boundary,
  input wire logic [31:0] i_virtual_address,
  // result
  output logic o_use_base_one,
  output logic [4:0] o_base_lsb
);
  logic [6:0] hi_bits;
  logic [6:0] hi_mask;
  // bits 31..25 of the address; N picks how many of them must be zero
  assign hi_bits = i_virtual_address[31:25];
  genvar g;
  generate
    for (g = 0; g < 7; g++) begin : g_mask
      assign hi_mask[g] = (32'(i_boundary) >= 32'(7 - g));
    end
  endgenerate
  assign o_use_base_one = (i_boundary != 3'h0) && ((hi_bits & hi_mask) != 7'h00);
  // lowest base address bit taken: 14 at N=0 down to 7 at N=7
  assign o_base_lsb = TBS_BASE_LSB_MAX - {2'h0, i_boundary};
endmodule : tbs_base_select
`default_nettype wire

// ===== rtl/tbs_domain_check.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_domain_check
  import tbs_pkg::*;
(
  // control
  input wire logic [31:0] i_domain_reg,
  input wire logic [3:0] i_domain,
  // result
  output logic o_domain_fault,
  output logic o_check_perm
);
  logic [1:0] fields [TBS_NUM_DOM];
  logic [1:0] sel;
  genvar g;
  generate
    for (g = 0; g < TBS_NUM_DOM; g++) begin : g_fld
      assign fields[g] = i_domain_reg[2*g+1:2*g];
    end
  endgenerate
  assign sel = fields[i_domain];
  assign o_domain_fault = (sel == TBS_DOM_NOACC) || (sel == TBS_DOM_RSVD);
  assign o_check_perm = (sel == TBS_DOM_CLIENT);
endmodule : tbs_domain_check
`default_nettype wire

// ===== rtl/tbs_table_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_table_ctrl
  import tbs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // coprocessor transfer
  input wire logic i_cp_valid,
  input wire logic i_cp_write,
  input wire logic [2:0] i_cp_op1,
  input wire logic [3:0] i_cp_crn,
  input wire logic [3:0] i_cp_crm,
  input wire logic [2:0] i_cp_op2,
  input wire logic [31:0] i_cp_wdata,
  input wire logic i_privileged,
  input wire logic i_secure,
  input wire logic i_secure_reg_write_lock,
  // lookup
  input wire logic i_lookup_valid,
  input wire logic i_tlb_miss,
  input wire logic [31:0] i_virtual_address,
  input wire logic [3:0] i_tlb_domain,
  // coprocessor answer
  output logic o_cp_done,
  output logic o_cp_undef,
  output logic o_cp_hit,
  output logic [31:0] o_cp_rdata,
  // lookup answer
  output logic o_lookup_done,
  output logic o_walk_start,
  output logic o_walk_secure,
  output logic o_walk_base_one,
  output logic [4:0] o_walk_base_lsb,
  output logic o_section_fault,
  output logic o_domain_fault,
  output logic o_check_perm
);
  logic [31:0] ctrl_s_r, ctrl_ns_r, dom_s_r, dom_ns_r;
  logic [31:0] ctrl_s_nxt, ctrl_ns_nxt, dom_s_nxt, dom_ns_nxt;
  logic cp_done_r, cp_undef_r, cp_hit_r;
  logic [31:0] cp_rdata_r;
  logic lk_done_r, walk_r, walk_sec_r, base_one_r, sec_fault_r, dom_fault_r, chk_r;
  logic [4:0] base_lsb_r;

  wire logic hit_ctrl;
  wire logic hit_dom;
  wire logic hit;
  wire logic undef;
  wire logic wr_ok;
  wire logic [31:0] ctrl_cur;
  wire logic [31:0] dom_cur;
  wire logic use_one;
  wire logic [4:0] base_lsb;
  wire logic disabled;
  wire logic dfault;
  wire logic chk;

  assign hit_ctrl = (i_cp_op1 == TBS_OP1_CTRL) && (i_cp_crn == TBS_CRN_CTRL) &&
                    (i_cp_crm == TBS_CRM_CTRL) && (i_cp_op2 == TBS_OP2_CTRL);
  assign hit_dom = (i_cp_op1 == TBS_OP1_DOM) && (i_cp_crn == TBS_CRN_DOM) &&
                   (i_cp_crm == TBS_CRM_DOM) && (i_cp_op2 == TBS_OP2_DOM);
  assign hit = i_cp_valid && (hit_ctrl || hit_dom);
  // user mode, or locked secure write, both refuse the transfer
  assign undef = hit && (!i_privileged ||
                 (i_cp_write && i_secure && i_secure_reg_write_lock));
  assign wr_ok = hit && i_cp_write && !undef;
  // the world of the current access picks the bank
  assign ctrl_cur = i_secure ? ctrl_s_r : ctrl_ns_r;
  assign dom_cur = i_secure ? dom_s_r : dom_ns_r;

  // unused bits held at zero, so they read back zero
  assign ctrl_s_nxt = (wr_ok && hit_ctrl && i_secure) ?
                      (i_cp_wdata & TBS_CTRL_MASK) : ctrl_s_r;
  assign ctrl_ns_nxt = (wr_ok && hit_ctrl && !i_secure) ?
                       (i_cp_wdata & TBS_CTRL_MASK) : ctrl_ns_r;
  assign dom_s_nxt = (wr_ok && hit_dom && i_secure) ? i_cp_wdata : dom_s_r;
  assign dom_ns_nxt = (wr_ok && hit_dom && !i_secure) ? i_cp_wdata : dom_ns_r;

  tbs_base_select u_sel (
    .i_boundary(ctrl_cur[TBS_BND_LSB +: TBS_BND_W]),
    .i_virtual_address(i_virtual_address),
    .o_use_base_one(use_one),
    .o_base_lsb(base_lsb)
  );

  tbs_domain_check u_dom (
    .i_domain_reg(dom_cur),
    .i_domain(i_tlb_domain),
    .o_domain_fault(dfault),
    .o_check_perm(chk)
  );

  assign disabled = use_one ? ctrl_cur[TBS_WD1_BIT] : ctrl_cur[TBS_WD0_BIT];

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_s_r <= TBS_CTRL_RST;
      ctrl_ns_r <= TBS_CTRL_RST;
      dom_s_r <= TBS_DOM_RST;
      dom_ns_r <= TBS_DOM_RST;
    end else begin
      ctrl_s_r <= ctrl_s_nxt;
      ctrl_ns_r <= ctrl_ns_nxt;
      dom_s_r <= dom_s_nxt;
      dom_ns_r <= dom_ns_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cp_done_r <= 1'b0;
      cp_undef_r <= 1'b0;
      cp_hit_r <= 1'b0;
      cp_rdata_r <= 32'h0000_0000;
    end else begin
      cp_done_r <= hit;
      cp_undef_r <= undef;
      cp_hit_r <= i_cp_valid && (hit_ctrl || hit_dom);
      cp_rdata_r <= (hit && !i_cp_write && !undef) ?
                    (hit_ctrl ? ctrl_cur : dom_cur) : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lk_done_r <= 1'b0;
      walk_r <= 1'b0;
      walk_sec_r <= 1'b0;
      base_one_r <= 1'b0;
      base_lsb_r <= 5'h00;
      sec_fault_r <= 1'b0;
      dom_fault_r <= 1'b0;
      chk_r <= 1'b0;
    end else begin
      lk_done_r <= i_lookup_valid;
      walk_r <= i_lookup_valid && i_tlb_miss && !disabled;
      walk_sec_r <= i_secure;
      base_one_r <= use_one;
      base_lsb_r <= use_one ? TBS_BASE_LSB_MAX : base_lsb;
      sec_fault_r <= i_lookup_valid && i_tlb_miss && disabled;
      dom_fault_r <= i_lookup_valid && !i_tlb_miss && dfault;
      chk_r <= i_lookup_valid && !i_tlb_miss && chk;
    end
  end

  assign o_cp_done = cp_done_r;
  assign o_cp_undef = cp_undef_r;
  assign o_cp_hit = cp_hit_r;
  assign o_cp_rdata = cp_rdata_r;
  assign o_lookup_done = lk_done_r;
  assign o_walk_start = walk_r;
  assign o_walk_secure = walk_sec_r;
  assign o_walk_base_one = base_one_r;
  assign o_walk_base_lsb = base_lsb_r;
  assign o_section_fault = sec_fault_r;
  assign o_domain_fault = dom_fault_r;
  assign o_check_perm = chk_r;

  // assertions
  wire logic lk_hit;
  wire logic lk_miss;
  wire logic [1:0] dom_code;
  assign lk_hit = i_lookup_valid && !i_tlb_miss;
  assign lk_miss = i_lookup_valid && i_tlb_miss;
  // field of the entry's domain in the current world's bank
  assign dom_code = dom_cur[{i_tlb_domain, 1'b0} +: 2];

  AST_WD1: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_lookup_valid && i_tlb_miss && use_one && ctrl_cur[TBS_WD1_BIT]
    |=> o_section_fault && !o_walk_start)
    else $error("base one disabled but no section fault");
  AST_WD0: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_lookup_valid && i_tlb_miss && !use_one && ctrl_cur[TBS_WD0_BIT]
    |=> o_section_fault && !o_walk_start)
    else $error("base zero disabled but no section fault");
  AST_WALK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_lookup_valid && i_tlb_miss && !disabled
    |=> o_walk_start && (o_walk_secure == $past(i_secure)))
    else $error("walk missing or wrong world");
  AST_N0: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h0 |=> !o_walk_base_one)
    else $error("boundary zero did not pick base zero");
  AST_HI: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h7 && i_virtual_address[31:25] == 7'h00 |=> !o_walk_base_one)
    else $error("zero upper bits did not pick base zero");
  AST_HI1: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h1 && i_virtual_address[31] |=> o_walk_base_one)
    else $error("set top bit did not pick base one");
  AST_LOCK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_cp_valid && hit_dom && i_cp_write && i_secure && i_secure_reg_write_lock
    |=> o_cp_undef && $stable(dom_s_r))
    else $error("locked secure write not refused");
  AST_USER: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && !i_privileged |=> o_cp_undef)
    else $error("user access not refused");
  AST_BANK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_ok && hit_dom && !i_secure |=> $stable(dom_s_r) && dom_ns_r == $past(i_cp_wdata))
    else $error("non-secure write reached wrong bank");
  AST_MGR: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_hit && (dom_code == TBS_DOM_MANAGER)
    |=> !o_check_perm && !o_domain_fault)
    else $error("manager domain was checked or faulted");

  // transfer decode and answer
  AST_CP_HIT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_cp_valid && (hit_ctrl || hit_dom)
    |=> o_cp_done && o_cp_hit)
    else $error("addressed transfer not answered");
  AST_CP_IGNORE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !hit
    |=> !o_cp_done && !o_cp_undef && (o_cp_rdata == 32'h0000_0000))
    else $error("answer without addressed transfer");
  AST_RD_CTRL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && hit_ctrl && !i_cp_write && i_privileged
    |=> !o_cp_undef && (o_cp_rdata == $past(ctrl_cur)))
    else $error("control read returned wrong bank");
  AST_RD_DOM: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && hit_dom && !i_cp_write && i_privileged
    |=> !o_cp_undef && (o_cp_rdata == $past(dom_cur)))
    else $error("domain read returned wrong bank");
  AST_WR_S_CTRL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_ok && hit_ctrl && i_secure
    |=> $stable(ctrl_ns_r) && (ctrl_s_r == ($past(i_cp_wdata) & TBS_CTRL_MASK)))
    else $error("secure control write reached wrong bank");
  AST_WR_NS_CTRL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_ok && hit_ctrl && !i_secure
    |=> $stable(ctrl_s_r) && (ctrl_ns_r == ($past(i_cp_wdata) & TBS_CTRL_MASK)))
    else $error("non-secure control write reached wrong bank");
  AST_WR_S_DOM: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    wr_ok && hit_dom && i_secure
    |=> $stable(dom_ns_r) && (dom_s_r == $past(i_cp_wdata)))
    else $error("secure domain write reached wrong bank");
  AST_IDLE_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !wr_ok
    |=> $stable(ctrl_s_r) && $stable(ctrl_ns_r) && $stable(dom_s_r) && $stable(dom_ns_r))
    else $error("register changed without a legal write");
  AST_LOCK_CTRL: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_cp_valid && hit_ctrl && i_cp_write && i_secure && i_secure_reg_write_lock
    |=> o_cp_undef && $stable(ctrl_s_r))
    else $error("locked secure control write not refused");
  AST_NS_UNLOCKED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && i_cp_write && i_privileged && !i_secure && i_secure_reg_write_lock
    |=> !o_cp_undef)
    else $error("non-secure write refused under lock");
  AST_LOCK_READ: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && !i_cp_write && i_privileged && i_secure_reg_write_lock
    |=> !o_cp_undef)
    else $error("privileged read refused under lock");
  AST_USER_RD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    hit && !i_privileged
    |=> (o_cp_rdata == 32'h0000_0000))
    else $error("user access returned register data");
  AST_UNUSED: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ((ctrl_s_r | ctrl_ns_r) & ~TBS_CTRL_MASK) == 32'h0000_0000)
    else $error("unused control bits not zero");

  // reset state
  AST_RST_OUT: assert property (@(posedge i_ref_clk)
    $past(i_reset)
    |-> !o_cp_done && !o_cp_undef && !o_lookup_done && !o_walk_start && !o_section_fault)
    else $error("outputs active after reset");
  AST_RST_REG: assert property (@(posedge i_ref_clk)
    $past(i_reset) |-> (ctrl_s_r == TBS_CTRL_RST) && (ctrl_ns_r == TBS_CTRL_RST)
    && (dom_s_r == TBS_DOM_RST) && (dom_ns_r == TBS_DOM_RST))
    else $error("registers not at reset value");

  // lookup answer
  AST_LK_DONE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    i_lookup_valid
    |=> o_lookup_done)
    else $error("lookup not answered");
  AST_LK_IDLE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    !i_lookup_valid |=> !o_lookup_done && !o_walk_start
    && !o_section_fault && !o_domain_fault && !o_check_perm)
    else $error("lookup answer without lookup");
  AST_HIT_NO_WALK: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_hit
    |=> !o_walk_start && !o_section_fault)
    else $error("walk or section fault on a hit");
  AST_MISS_NO_DOM: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_miss
    |=> !o_domain_fault && !o_check_perm)
    else $error("domain result on a miss");
  AST_NOACC: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_hit && (dom_code == TBS_DOM_NOACC)
    |=> o_domain_fault && !o_check_perm)
    else $error("no-access domain did not fault");
  AST_CLIENT: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_hit && (dom_code == TBS_DOM_CLIENT)
    |=> o_check_perm && !o_domain_fault)
    else $error("client domain not checked");
  AST_RSVD: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    lk_hit && (dom_code == TBS_DOM_RSVD)
    |=> o_domain_fault && !o_check_perm)
    else $error("reserved domain did not fault");

  // base selection
  AST_N0_LSB: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h0
    |=> (o_walk_base_lsb == TBS_BASE_LSB_MAX))
    else $error("boundary zero used wrong base bits");
  AST_N3_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h3 && i_virtual_address[31:29] == 3'h0
    |=> !o_walk_base_one && (o_walk_base_lsb == TBS_BASE_LSB_MAX - 5'h03))
    else $error("boundary three base zero wrong");
  AST_N3_ONE: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h3 && i_virtual_address[29]
    |=> o_walk_base_one)
    else $error("boundary three did not pick base one");
  AST_N7_LSB: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] == 3'h7 && i_virtual_address[31:25] == 7'h00
    |=> (o_walk_base_lsb == TBS_BASE_LSB_MAX - 5'h07))
    else $error("boundary seven used wrong base bits");
  AST_BASE1_LSB: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    ctrl_cur[2:0] != 3'h0 && i_virtual_address[31]
    |=> o_walk_base_one && (o_walk_base_lsb == TBS_BASE_LSB_MAX))
    else $error("base one used wrong base bits");
  COV_FAULT: cover property (@(posedge i_ref_clk) o_section_fault);
  COV_WALK1: cover property (@(posedge i_ref_clk) o_walk_start && o_walk_base_one);
  COV_UNDEF: cover property (@(posedge i_ref_clk) o_cp_undef);
  COV_DOMF: cover property (@(posedge i_ref_clk) o_domain_fault);
  COV_MGR: cover property (@(posedge i_ref_clk) lk_hit && (dom_code == TBS_DOM_MANAGER));
endmodule : tbs_table_ctrl
`default_nettype wire

// ===== test/tbs_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_core_model (
  // clock
  input wire logic i_ref_clk,
  // coprocessor transfer
  output logic o_cp_valid,
  output logic o_cp_write,
  output logic [13:0] o_cp_sel,
  output logic [31:0] o_cp_wdata,
  output logic [2:0] o_mode,
  // lookup
  output logic o_lookup_valid,
  output logic o_tlb_miss,
  output logic [31:0] o_virtual_address,
  output logic [3:0] o_tlb_domain
);
  initial begin
    {o_cp_valid, o_cp_write, o_cp_sel, o_cp_wdata, o_mode} = '0;
    {o_lookup_valid, o_tlb_miss, o_virtual_address, o_tlb_domain} = '0;
  end
  // mode is {privileged, secure, lock}; request held over exactly one sampling edge
  task automatic cp(input logic w, input logic [13:0] sel, input logic [31:0] d,
                    input logic [2:0] m);
    @(posedge i_ref_clk);
    {o_cp_valid, o_cp_write, o_cp_sel, o_cp_wdata, o_mode} <= {1'b1, w, sel, d, m};
    @(posedge i_ref_clk);
    o_cp_valid <= 1'b0;
    // released data flipped so stale values never look valid
    o_cp_wdata <= ~d;
  endtask : cp
  task automatic lk(input logic miss, input logic [31:0] va, input logic [3:0] dm,
                    input logic s);
    @(posedge i_ref_clk);
    {o_lookup_valid, o_tlb_miss, o_virtual_address, o_tlb_domain} <= {1'b1, miss, va, dm};
    o_mode[1] <= s;
    @(posedge i_ref_clk);
    o_lookup_valid <= 1'b0;
    o_virtual_address <= ~va;
  endtask : lk
endmodule : tbs_core_model
`default_nettype wire

// ===== test/tbs_table_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tbs_table_ctrl_tb_top;
  import tbs_pkg::*;
  localparam logic [13:0] SEL_CTRL = {TBS_OP1_CTRL, TBS_CRN_CTRL, TBS_CRM_CTRL, TBS_OP2_CTRL};
  localparam logic [13:0] SEL_DOM = {TBS_OP1_DOM, TBS_CRN_DOM, TBS_CRM_DOM, TBS_OP2_DOM};
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cp_valid, i_cp_write, i_lookup_valid, i_tlb_miss;
  logic o_cp_done, o_cp_undef, o_cp_hit, o_lookup_done, o_walk_start, o_walk_secure;
  logic o_walk_base_one, o_section_fault, o_domain_fault, o_check_perm;
  logic [2:0] mode;
  logic [3:0] i_tlb_domain;
  logic [4:0] o_walk_base_lsb;
  logic [13:0] cp_sel;
  logic [31:0] i_cp_wdata, i_virtual_address, o_cp_rdata;
  logic [31:0] m_ctrl [2];
  logic [31:0] m_dom [2];
  int n_mismatch = 0;
  int num_checks = 0;
  wire [4:0] lk_flags = {o_lookup_done, o_walk_start, o_section_fault, o_domain_fault,
                         o_check_perm};
  always #20 i_ref_clk = ~i_ref_clk;
  tbs_table_ctrl i_tbs_table_ctrl (
    .i_ref_clk, .i_reset, .i_cp_valid, .i_cp_write, .i_cp_op1(cp_sel[13:11]),
    .i_cp_crn(cp_sel[10:7]), .i_cp_crm(cp_sel[6:3]), .i_cp_op2(cp_sel[2:0]), .i_cp_wdata,
    .i_privileged(mode[2]), .i_secure(mode[1]), .i_secure_reg_write_lock(mode[0]),
    .i_lookup_valid, .i_tlb_miss, .i_virtual_address, .i_tlb_domain, .o_cp_done, .o_cp_undef,
    .o_cp_hit, .o_cp_rdata, .o_lookup_done, .o_walk_start, .o_walk_secure, .o_walk_base_one,
    .o_walk_base_lsb, .o_section_fault, .o_domain_fault, .o_check_perm);
  tbs_core_model i_tbs_core_model (.i_ref_clk, .o_cp_valid(i_cp_valid), .o_cp_write(i_cp_write),
    .o_cp_sel(cp_sel), .o_cp_wdata(i_cp_wdata), .o_mode(mode), .o_lookup_valid(i_lookup_valid),
    .o_tlb_miss(i_tlb_miss), .o_virtual_address(i_virtual_address), .o_tlb_domain(i_tlb_domain));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic do_cp(input logic w, input logic [13:0] sel, input logic [31:0] d,
                       input logic [2:0] m);
    logic hit, ud, s, ok;
    logic [31:0] rd;
    s = m[1];
    hit = (sel == SEL_CTRL) || (sel == SEL_DOM);
    ud = hit && (!m[2] || (w && s && m[0]));
    ok = hit && !ud;
    rd = (ok && !w) ? ((sel == SEL_CTRL) ? m_ctrl[s] : m_dom[s]) : 32'h0;
    if (ok && w && sel == SEL_CTRL) m_ctrl[s] = d & TBS_CTRL_MASK;
    if (ok && w && sel == SEL_DOM) m_dom[s] = d;
    i_tbs_core_model.cp(w, sel, d, m);
    #1;
    chk("cp_resp", 32'({o_cp_done, o_cp_hit, o_cp_undef}), 32'({hit, hit, ud}));
    chk("cp_rdata", o_cp_rdata, rd);
  endtask : do_cp
  task automatic do_lk(input logic miss, input logic [31:0] va, input logic [3:0] dm,
                       input logic s);
    int n;
    logic one, wd;
    logic [1:0] code;
    logic [4:0] ef;
    logic [5:0] eb;
    n = m_ctrl[s][2:0];
    one = (va >> (32 - n)) != 0;
    wd = m_ctrl[s][one ? TBS_WD1_BIT : TBS_WD0_BIT];
    code = m_dom[s][2 * dm +: 2];
    ef = {1'b1, miss && !wd, miss && wd, !miss && !code[0], !miss && code == 2'h1};
    eb = one ? {1'b1, TBS_BASE_LSB_MAX} : {1'b0, TBS_BASE_LSB_MAX - 5'(n)};
    i_tbs_core_model.lk(miss, va, dm, s);
    #1;
    chk("lk_flags", 32'(lk_flags), 32'(ef));
    if (miss) chk("lk_base", 32'({o_walk_base_one, o_walk_base_lsb}), 32'(eb));
    if (miss && !wd) chk("walk_world", 32'(o_walk_secure), 32'(s));
  endtask : do_lk
  initial begin
    #(5000 * 40);
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [13:0] sel;
    logic [2:0] m;
    void'($urandom(34042));
    m_ctrl = '{TBS_CTRL_RST, TBS_CTRL_RST};
    m_dom = '{TBS_DOM_RST, TBS_DOM_RST};
    repeat (20) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++) do_cp(1'b0, i[0] ? SEL_DOM : SEL_CTRL, 32'h0, {1'b1, i[1], 1'b0});
    do_lk(1'b1, $urandom, 4'h0, 1'b1);
    // boundary field stays 0..7 and unused bits stay zero
    for (int n = 0; n < 8; n++) begin
      do_cp(1'b1, SEL_CTRL, 32'({2'($urandom), 1'b0, 3'(n)}), 3'b100);
      d = 32'(64'h1 << (32 - n));
      do_lk(1'b1, d, 4'h0, 1'b0);
      do_lk(1'b1, d - 32'h1, 4'h0, 1'b0);
    end
    do_cp(1'b1, SEL_DOM, 32'hE4E4_1B1B, 3'b100);
    for (int k = 0; k < 16; k++) do_lk(1'b0, $urandom, 4'(k), 1'b0);
    for (int i = 0; i < 600; i++) begin
      sel = ($urandom % 3 == 0) ? SEL_DOM : SEL_CTRL;
      // neighbouring selector that belongs to another register
      if ($urandom % 8 == 0) sel[2:0] = 3'h1;
      d = (sel == SEL_CTRL) ? ($urandom & TBS_CTRL_MASK) : $urandom;
      m = 3'($urandom) | (($urandom % 4 != 0) ? 3'h4 : 3'h0);
      do_cp(1'($urandom), sel, d, m);
      do_lk(1'($urandom), $urandom >> ($urandom % 32), 4'($urandom), 1'($urandom));
    end
    complete_run();
  end
endmodule : tbs_table_ctrl_tb_top
`default_nettype wire
